// ---- hdl/psc_counters.sv ----
// Statistics counter bank for a two-port switch with indirect host reads.
// Assumes frame events and host strobes are synchronous to SYS_CLK_I.
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_counters
  import psc_pkg::*;
(
  // Clock and reset.
  input  wire logic             SYS_CLK_I,
  input  wire logic             RSTN_I,
  // Frame events from the two MACs.
  input  wire psc_rx_ev_t [1:0] RX_EV_I,
  input  wire psc_tx_ev_t [1:0] TX_EV_I,
  input  wire logic [1:0]       RX_DROP_I,
  input  wire logic [1:0]       TX_DROP_I,
  input  wire logic             MAX_LONG_I,
  // Host register port.
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  input  wire logic [7:0]       REG_ADDR_I,
  input  wire logic [15:0]      REG_WDATA_I,
  output logic      [15:0]      REG_RDATA_O
);

  psc_state_t           st_r;
  psc_state_t           st_nxt;
  logic [63:0][10:0]    inc_all;
  psc_cnt_t [63:0]      cnt_nxt;
  logic [63:0]          clr_hit;
  logic                 rd_go;
  logic [9:0]           rd_addr;
  logic [10:0]          max_len;

  assign max_len = MAX_LONG_I ? `PSC_LEN_MAX_LONG : `PSC_LEN_MAX_SHORT;
  assign rd_addr = REG_WDATA_I[9:0];
  assign rd_go   = REG_WR_I && (REG_ADDR_I == `PSC_OFF_CTRL)
                && REG_WDATA_I[`PSC_CMD_READ_BIT]
                && (REG_WDATA_I[`PSC_TBL_HI:`PSC_TBL_LO] == `PSC_TBL_COUNTERS);

  genvar p;
  genvar e;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [31:0][10:0] inc;
      logic              rx_bad;
      logic              rx_in;
      logic              rx_good;
      psc_rx_ev_t        rx;
      psc_tx_ev_t        tx;
      assign rx      = RX_EV_I[p];
      assign tx      = TX_EV_I[p];
      assign rx_bad  = !rx.crc_ok || rx.sym || rx.dribble;
      assign rx_in   = (rx.len >= `PSC_LEN_MIN) && (rx.len <= max_len);
      assign rx_good = !rx_bad && rx_in;
      always_comb begin
        inc = '0;
        if (rx.vld) begin
          inc[rx.hi ? `PSC_C_RX_HI : `PSC_C_RX_LO] = rx.len;
          inc[`PSC_C_RX_SHORT]    = {10'h000, (rx.len < `PSC_LEN_MIN) && !rx_bad};
          inc[`PSC_C_RX_RUNT]     = {10'h000, (rx.len < `PSC_LEN_MIN) && rx_bad};
          inc[`PSC_C_RX_LONG]     = {10'h000, (rx.len > max_len) && !rx_bad};
          inc[`PSC_C_RX_LONG_ERR] = {10'h000, (rx.len > max_len) && rx_bad};
          inc[`PSC_C_RX_SYMBOL]   = {10'h000, rx_in && rx.sym};
          inc[`PSC_C_RX_CHECK]    = {10'h000, rx_in && !rx.crc_ok && !rx.dribble};
          inc[`PSC_C_RX_MISAL]    = {10'h000, rx_in && !rx.crc_ok && rx.dribble};
          inc[`PSC_C_RX_CTRL]     = {10'h000, rx.ctrl};
          inc[`PSC_C_RX_PAUSE]    = {10'h000, rx.ctrl && rx.pause_op
                                     && (rx.len >= `PSC_LEN_MIN) && rx.crc_ok};
          inc[`PSC_C_RX_BCAST]    = {10'h000, rx_good && rx.bcast};
          inc[`PSC_C_RX_MCAST]    = {10'h000, rx_good && rx.mcast && !rx.bcast
                                     && !rx.ctrl};
          inc[`PSC_C_RX_UCAST]    = {10'h000, rx_good && !rx.mcast && !rx.bcast};
          // Frames above the maximum land in no bin, as with the error classes.
          inc[`PSC_C_RX_BIN0]     = {10'h000, rx.len == `PSC_LEN_MIN};
          inc[`PSC_C_RX_BIN0 + 5'h01] = {10'h000, (rx.len > `PSC_LEN_MIN)
                                         && (rx.len < `PSC_LEN_128)};
          inc[`PSC_C_RX_BIN0 + 5'h02] = {10'h000, (rx.len >= `PSC_LEN_128)
                                         && (rx.len < `PSC_LEN_256)};
          inc[`PSC_C_RX_BIN0 + 5'h03] = {10'h000, (rx.len >= `PSC_LEN_256)
                                         && (rx.len < `PSC_LEN_512)};
          inc[`PSC_C_RX_BIN0 + 5'h04] = {10'h000, (rx.len >= `PSC_LEN_512)
                                         && (rx.len < `PSC_LEN_1024)};
          inc[`PSC_C_RX_BIN0 + 5'h05] = {10'h000, (rx.len >= `PSC_LEN_1024)
                                         && (rx.len <= max_len)};
        end
        if (tx.vld) begin
          if (tx.ok) begin
            inc[tx.hi ? `PSC_C_TX_HI : `PSC_C_TX_LO] = tx.len;
          end
          inc[`PSC_C_TX_PAUSE]    = {10'h000, tx.ok && tx.pause};
          inc[`PSC_C_TX_BCAST]    = {10'h000, tx.ok && tx.bcast};
          inc[`PSC_C_TX_MCAST]    = {10'h000, tx.ok && tx.mcast && !tx.bcast};
          inc[`PSC_C_TX_UCAST]    = {10'h000, tx.ok && !tx.mcast && !tx.bcast};
          inc[`PSC_C_TX_POSTPONE] = {10'h000, tx.postponed};
          inc[`PSC_C_TX_ABANDON]  = {10'h000, tx.abandoned};
          inc[`PSC_C_TX_ONE_HIT]  = {10'h000, tx.ok && (tx.hits == 5'h01)};
          inc[`PSC_C_TX_MANY_HIT] = {10'h000, tx.ok && (tx.hits > 5'h01)};
        end
        // Collision pulses are independent of the frame-done event.
        inc[`PSC_C_TX_LATE]     = {10'h000, tx.late_hit};
        inc[`PSC_C_TX_ALL_HITS] = {10'h000, tx.hit};
      end
      assign inc_all[p*32 +: 32] = inc;
    end

    for (e = 0; e < 64; e++) begin : g_entry
      logic [30:0] sum;
      assign sum = {1'b0, st_r.cnt[e].val} + {20'h00000, inc_all[e]};
      // A clearing read keeps the increment of the same cycle.
      assign cnt_nxt[e] = clr_hit[e] ? {1'b0, 19'h00000, inc_all[e]}
                                     : {st_r.cnt[e].ovf | sum[30], sum[29:0]};
    end
  endgenerate

  always_comb begin
    clr_hit = '0;
    if (rd_go && (rd_addr < `PSC_PORT_SPAN)) begin
      clr_hit[rd_addr[5:0]] = 1'b1;
    end
  end

  always_comb begin
    st_nxt     = st_r;
    st_nxt.cnt = cnt_nxt;
    st_nxt.drop[0] = st_r.drop[0] + {15'h0000, TX_DROP_I[0]};
    st_nxt.drop[1] = st_r.drop[1] + {15'h0000, TX_DROP_I[1]};
    st_nxt.drop[2] = st_r.drop[2] + {15'h0000, RX_DROP_I[0]};
    st_nxt.drop[3] = st_r.drop[3] + {15'h0000, RX_DROP_I[1]};
    if (REG_WR_I && (REG_ADDR_I == `PSC_OFF_CTRL)) begin
      st_nxt.ctrl = REG_WDATA_I;
    end
    if (rd_go) begin
      // The snapshot is taken before this cycle's increment, which survives the clear.
      if (rd_addr < `PSC_PORT_SPAN) begin
        st_nxt.data_hi = {st_r.cnt[rd_addr[5:0]].ovf, 1'b1,
                          st_r.cnt[rd_addr[5:0]].val[29:16]};
        st_nxt.data_lo = st_r.cnt[rd_addr[5:0]].val[15:0];
      end else begin
        st_nxt.data_hi = 16'h0000;
        case (rd_addr)
          `PSC_DROP_TX1: st_nxt.data_lo = st_r.drop[0];
          `PSC_DROP_TX2: st_nxt.data_lo = st_r.drop[1];
          `PSC_DROP_RX1: st_nxt.data_lo = st_r.drop[2];
          `PSC_DROP_RX2: st_nxt.data_lo = st_r.drop[3];
          default:       st_nxt.data_lo = 16'h0000;
        endcase
      end
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `PSC_OFF_CTRL:    st_nxt.rdata = st_r.ctrl;
        `PSC_OFF_DATA_LO: st_nxt.rdata = st_r.data_lo;
        `PSC_OFF_DATA_HI: st_nxt.rdata = st_r.data_hi;
        default:          st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA_O = st_r.rdata;

endmodule

// ---- hdl/psc_map.svh ----
// Address map, field positions and limits of the port statistics counter bank.
// Assumes one system clock; included by the counter bank only, not by the package.
// Function
// - Thirty-two counters per port from frame events.
// - Bit 31 flags overflow since last clear.
// - Bit 30 valid; host rereads upper half if zero.
// - Port counters clear when read indirectly.
// - Port one counters at 0x00 to 0x1f.
// - Port two counters at 0x20 to 0x3f.
// - Control write with read code latches counter.
// - Upper half bits 31-16, lower half 15-0.
// - Offsets 0x0/0x1 receive low/high priority octets.
// - 0x2 short good frames, 0x3 runt errors.
// - 0x4 long good, 0x5 long errored frames.
// - 0x7 check errors, 0x8 misaligned, 64..max bytes.
// - 0x9 control frames, 0xA qualified pause frames.
// - 0xE-0x13 receive length bins, bad included.
// - 0xB-0xD good broadcast, multicast, unicast received.
// - 0x14/0x15 transmit octets, 0x17 transmit pause.
// - 0x16 late hits, 0x18-0x1A transmit casts.
// - 0x1B transmits postponed by busy medium.
// - 0x1C all hits half duplex, 0x1D abandoned.
// - 0x1E one hit, 0x1F many hits.
// - Dropped counters at 0x100, 0x101, 0x103, 0x104.
// - Dropped counters 16 bits, no flags.
// - Dropped counters keep value when read.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_OFF_CTRL      8'h00
`define PSC_OFF_DATA_LO   8'h08
`define PSC_OFF_DATA_HI   8'h0a
`define PSC_CMD_READ_BIT  12
`define PSC_TBL_HI        11
`define PSC_TBL_LO        10
`define PSC_TBL_COUNTERS  2'h3
`define PSC_PORT_SPAN     10'h040
`define PSC_DROP_TX1      10'h100
`define PSC_DROP_TX2      10'h101
`define PSC_DROP_RX1      10'h103
`define PSC_DROP_RX2      10'h104
`define PSC_LEN_MIN       11'h040
`define PSC_LEN_128       11'h080
`define PSC_LEN_256       11'h100
`define PSC_LEN_512       11'h200
`define PSC_LEN_1024      11'h400
`define PSC_LEN_MAX_LONG  11'h600
`define PSC_LEN_MAX_SHORT 11'h5f2
`define PSC_C_RX_LO       5'h00
`define PSC_C_RX_HI       5'h01
`define PSC_C_RX_SHORT    5'h02
`define PSC_C_RX_RUNT     5'h03
`define PSC_C_RX_LONG     5'h04
`define PSC_C_RX_LONG_ERR 5'h05
`define PSC_C_RX_SYMBOL   5'h06
`define PSC_C_RX_CHECK    5'h07
`define PSC_C_RX_MISAL    5'h08
`define PSC_C_RX_CTRL     5'h09
`define PSC_C_RX_PAUSE    5'h0a
`define PSC_C_RX_BCAST    5'h0b
`define PSC_C_RX_MCAST    5'h0c
`define PSC_C_RX_UCAST    5'h0d
`define PSC_C_RX_BIN0     5'h0e
`define PSC_C_TX_LO       5'h14
`define PSC_C_TX_HI       5'h15
`define PSC_C_TX_LATE     5'h16
`define PSC_C_TX_PAUSE    5'h17
`define PSC_C_TX_BCAST    5'h18
`define PSC_C_TX_MCAST    5'h19
`define PSC_C_TX_UCAST    5'h1a
`define PSC_C_TX_POSTPONE 5'h1b
`define PSC_C_TX_ALL_HITS 5'h1c
`define PSC_C_TX_ABANDON  5'h1d
`define PSC_C_TX_ONE_HIT  5'h1e
`define PSC_C_TX_MANY_HIT 5'h1f
`endif

// ---- hdl/psc_pkg.sv ----
// Types shared by the port statistics counter bank and its surroundings.
// Assumes the MAC reports each frame as a one-cycle event on the system clock.
package psc_pkg;
  typedef struct packed {
    logic        vld;
    logic [10:0] len;
    logic        hi;
    logic        crc_ok;
    logic        sym;
    logic        dribble;
    logic        bcast;
    logic        mcast;
    logic        ctrl;
    logic        pause_op;
  } psc_rx_ev_t;
  typedef struct packed {
    logic        vld;
    logic [10:0] len;
    logic        hi;
    logic        ok;
    logic        pause;
    logic        bcast;
    logic        mcast;
    logic        postponed;
    logic [4:0]  hits;
    logic        abandoned;
    logic        late_hit;
    logic        hit;
  } psc_tx_ev_t;
  typedef struct packed {
    logic        ovf;
    logic [29:0] val;
  } psc_cnt_t;
  typedef struct packed {
    psc_cnt_t [63:0]       cnt;
    logic [3:0][15:0]      drop;
    logic [15:0]           ctrl;
    logic [15:0]           data_hi;
    logic [15:0]           data_lo;
    logic [15:0]           rdata;
  } psc_state_t;
endpackage

// ---- verif/psc_counters_checker.sv ----
// Assertions on the register port of the counter bank.
// Assumes it is bound to psc_counters and sees its host-side ports only.
`timescale 1ns/1ps
module psc_counters_checker (
  input wire logic        SYS_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence trig_s(lo, hi);
    REG_WR_I && REG_ADDR_I == 8'h00 && REG_WDATA_I[12:10] == 3'h7
      && REG_WDATA_I[9:0] >= lo && REG_WDATA_I[9:0] <= hi;
  endsequence
  sequence rd_s(a);
    REG_RD_I && !REG_WR_I && REG_ADDR_I == a;
  endsequence
  reset_zero_a: assert property (disable iff (1'b0) !RSTN_I |=> REG_RDATA_O == 16'h0)
    else $error("Read data not cleared by reset");
  rdata_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("Read data moved without a read");
  bad_offset_a: assert property (REG_RD_I && !(REG_ADDR_I inside {8'h00, 8'h08, 8'h0a})
    |=> REG_RDATA_O == 16'h0) else $error("Unmapped offset gave data");
  ctrl_back_a: assert property (REG_WR_I && REG_ADDR_I == 8'h00 ##1 rd_s(8'h00)
    |=> REG_RDATA_O == $past(REG_WDATA_I, 2)) else $error("Control word not read back");
  valid_flag_a: assert property (trig_s(10'h000, 10'h03f) ##1 rd_s(8'h0a)
    |=> REG_RDATA_O[14]) else $error("Valid flag low after snapshot");
  bad_cnt_hi_a: assert property (trig_s(10'h040, 10'h0ff) ##1 rd_s(8'h0a)
    |=> REG_RDATA_O == 16'h0) else $error("Unmapped counter upper not zero");
  bad_cnt_lo_a: assert property (trig_s(10'h040, 10'h0ff) ##1 rd_s(8'h0a) ##1 rd_s(8'h08)
    |=> REG_RDATA_O == 16'h0) else $error("Unmapped counter lower not zero");
  lo_stable_a: assert property (rd_s(8'h08) ##1 rd_s(8'h08) |=> $stable(REG_RDATA_O))
    else $error("Lower half changed between reads");
endmodule
bind psc_counters psc_counters_checker u_chk (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O));

// ---- verif/psc_counters_test.sv ----
// Self-checking bench for the port statistics counter bank.
// Assumes psc_host drives the register port; frame events come from here.
`timescale 1ns/1ps
module psc_counters_test;
  import psc_pkg::*;
  logic             sys_clk;
  logic             rstn;
  psc_rx_ev_t [1:0] rx_ev;
  psc_tx_ev_t [1:0] tx_ev;
  logic [1:0]       rx_drop;
  logic [1:0]       tx_drop;
  logic             max_long;
  logic             wr;
  logic             rd;
  logic [7:0]       addr;
  logic [15:0]      wdata;
  logic [15:0]      rdata;
  logic             pend = 1'b0;
  int               num_errors = 0;
  int               num_checks = 0;
  int               n;
  psc_counters dut (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .RX_EV_I(rx_ev), .TX_EV_I(tx_ev),
    .RX_DROP_I(rx_drop), .TX_DROP_I(tx_drop), .MAX_LONG_I(max_long), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata));
  psc_host host (.clk_i(sys_clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Read data is due in the cycle after the read strobe was taken.
  always @(posedge sys_clk) begin
    if (pend) begin
      cmp("read data", host.exp_q.pop_front(), rdata);
    end
    pend = rd && rstn;
  end
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    rx_ev = '0;
    tx_ev = '0;
    rx_drop = 2'b00;
    tx_drop = 2'b00;
    max_long = 1'b1;
    void'($urandom(32'h7ded));
    repeat (4) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    host.step();
    host.rd(8'h04, 16'h0);
    host.wr(8'h00, 16'h0a5a);
    host.rd(8'h00, 16'h0a5a);
    host.rd_cnt(10'h00e, 32'h4000_0000);
    rx_ev[0] = '{vld:1'b1, len:11'd64, crc_ok:1'b1, bcast:1'b1, mcast:1'b1, default:1'b0};
    host.step();
    rx_ev = '0;
    host.rd_cnt(10'h000, 32'h4000_0040);
    host.rd_cnt(10'h00e, 32'h4000_0001);
    host.rd_cnt(10'h00b, 32'h4000_0001);
    host.rd_cnt(10'h00c, 32'h4000_0000);
    host.rd_cnt(10'h00e, 32'h4000_0000);
    n = $urandom_range(127, 65);
    rx_ev[1] = '{vld:1'b1, len:n[10:0], hi:1'b1, default:1'b0};
    host.step();
    rx_ev = '0;
    host.rd_cnt(10'h021, 32'h4000_0000 | n);
    host.rd_cnt(10'h02f, 32'h4000_0001);
    host.rd_cnt(10'h027, 32'h4000_0001);
    tx_ev[1] = '{vld:1'b1, len:11'd200, ok:1'b1, hits:5'd1, default:1'b0};
    host.step();
    tx_ev = '0;
    host.rd_cnt(10'h034, 32'h4000_00c8);
    host.rd_cnt(10'h03a, 32'h4000_0001);
    host.rd_cnt(10'h03e, 32'h4000_0001);
    rx_drop = 2'b01;
    tx_drop = 2'b10;
    host.step();
    tx_drop = 2'b00;
    host.step();
    rx_drop = 2'b00;
    host.rd_cnt(10'h103, 32'h2);
    host.rd_cnt(10'h101, 32'h1);
    host.wr(8'h00, 16'h1401);
    host.rd(8'h08, 16'h1);
    host.rd(8'h08, 16'h1);
    host.rd_cnt(10'h103, 32'h2);
    host.rd_cnt(10'h080, 32'h0);
    tx_drop = 2'b01;
    rx_drop = 2'b10;
    host.step();
    tx_drop = 2'b00;
    rx_drop = 2'b00;
    host.rd_cnt(10'h100, 32'h1);
    host.rd_cnt(10'h104, 32'h1);
    rx_ev[0] = '{vld:1'b1, len:11'h040, crc_ok:1'b1, mcast:1'b1, ctrl:1'b1, pause_op:1'b1,
                 default:1'b0};
    rx_ev[1] = '{vld:1'b1, len:11'h064, sym:1'b1, dribble:1'b1, default:1'b0};
    host.step();
    rx_ev[0] = '{vld:1'b1, len:11'h028, crc_ok:1'b1, default:1'b0};
    rx_ev[1] = '{vld:1'b1, len:11'h028, default:1'b0};
    tx_ev[0] = '{vld:1'b1, len:11'h040, hi:1'b1, ok:1'b1, pause:1'b1, mcast:1'b1, postponed:1'b1,
                 hits:5'h03, late_hit:1'b1, hit:1'b1, default:1'b0};
    tx_ev[1] = '{vld:1'b1, len:11'h040, hits:5'h10, abandoned:1'b1, default:1'b0};
    host.step();
    rx_ev = '0;
    tx_ev = '0;
    host.rd_cnt(10'h009, 32'h4000_0001);
    host.rd_cnt(10'h00a, 32'h4000_0001);
    host.rd_cnt(10'h00c, 32'h4000_0000);
    host.rd_cnt(10'h028, 32'h4000_0001);
    host.rd_cnt(10'h002, 32'h4000_0001);
    host.rd_cnt(10'h023, 32'h4000_0001);
    host.rd_cnt(10'h015, 32'h4000_0040);
    host.rd_cnt(10'h017, 32'h4000_0001);
    host.rd_cnt(10'h016, 32'h4000_0001);
    host.rd_cnt(10'h019, 32'h4000_0001);
    host.rd_cnt(10'h01b, 32'h4000_0001);
    host.rd_cnt(10'h01c, 32'h4000_0001);
    host.rd_cnt(10'h03d, 32'h4000_0001);
    host.rd_cnt(10'h01f, 32'h4000_0001);
    rx_ev[0] = '{vld:1'b1, len:11'h5fa, crc_ok:1'b1, default:1'b0};
    host.wr(8'h00, 16'h1c13);
    rx_ev = '0;
    host.rd(8'h0a, 16'h4000);
    host.rd(8'h08, 16'h0000);
    host.rd_cnt(10'h013, 32'h4000_0001);
    max_long = 1'b0;
    rx_ev[0] = '{vld:1'b1, len:11'h5fa, crc_ok:1'b1, default:1'b0};
    rx_ev[1] = '{vld:1'b1, len:11'h5fa, default:1'b0};
    host.step();
    rx_ev = '0;
    host.rd_cnt(10'h004, 32'h4000_0001);
    host.rd_cnt(10'h025, 32'h4000_0001);
    host.rd_cnt(10'h013, 32'h4000_0000);
    host.idle();
    host.idle();
    end_of_test();
  end
endmodule

// ---- verif/psc_host.sv ----
// Host model that reads the counters through the indirect register port.
// Assumes its tasks are entered 1 ns after a rising edge of clk_i.
`timescale 1ns/1ps
module psc_host (
  input  wire logic  clk_i,
  output logic       wr_o,
  output logic       rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  logic [15:0] exp_q[$];
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0;
  end
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic idle();
    wr_o = 1'b0;
    rd_o = 1'b0;
    step();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    rd_o = 1'b0;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wr_o = 1'b0;
    rd_o = 1'b1;
    addr_o = a;
    exp_q.push_back(e);
    step();
  endtask
  // Drop counters carry no flags, so only their lower half is fetched.
  task automatic rd_cnt(input logic [9:0] a, input logic [31:0] e);
    wr(8'h00, {6'h07, a});
    if (a < 10'h100) rd(8'h0a, e[31:16]);
    rd(8'h08, e[15:0]);
    idle();
  endtask
endmodule
